// ---- snep_pkg.sv ----
package snep_pkg;
  localparam int TW = 5;   // width of every programmed time field except burst_beat_time, which is 4 bits
  localparam int NW = 5;   // width of the burst beat count (1 to 16)
  localparam int UW = 10;  // width of the time-unit counter
  localparam int CW = 12;  // width of the functional clock counter
  localparam int XW = 9;   // width of the burst extension term
  localparam int PW = 2;   // width of the clock phase counter
  localparam logic [TW-1:0] TIME_ZERO = 5'h00;
  localparam logic [NW-1:0] BEAT_ONE  = 5'h01;
  localparam logic [PW-1:0] PHASE_RST = 2'h0;
  localparam int FCLK_PERIOD_NS = 10;
  typedef enum logic [0:0] {
    SNEP_IDLE = 1'b0,
    SNEP_RUN  = 1'b1
  } snep_state_t;
endpackage

// ---- snep_launch.sv ----
`timescale 1ns/100ps
module snep_launch
  import snep_pkg::*;
(
  input  wire logic mclk,        // functional clock
  input  wire logic nrst,        // synchronous reset, active low
  input  wire logic level_d,     // next asserted state of the strobe
  input  wire logic half_shift,  // delay the strobe by half a clock
  output logic      strobe_n     // strobe pin, active low
);
  logic pos_q;
  logic neg_q;
  logic pos_d;

  always_comb begin
    pos_d = level_d;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pos_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
    end
  end

  // the falling edge copy lags by half a clock; nothing else moves off the rising edge
  always_ff @(negedge mclk) begin
    if (!nrst) begin
      neg_q <= 1'b0;
    end else begin
      neg_q <= pos_q; // R18
    end
  end

  // a select between two flops rather than a single flop; the shift needs both edges
  assign strobe_n = half_shift ? ~neg_q : ~pos_q; // R18

  AST_ALIGNED: assert property (@(posedge mclk) disable iff (!nrst) // R18
    !half_shift |-> strobe_n == ~$past(level_d))
    else $error("unshifted strobe not on rising edge");
endmodule

// ---- snep_top.sv ----
`timescale 1ns/100ps
// Operation
// R01: single read select low: release minus assert, scaled
// R02: burst read select adds beats times beat time
// R03: burst write select uses write release time
// R04: memory clock starts after first clock delay
// R05: byte enables low for cycle length plus beats
// R06: enables and latch release at cycle minus sample; code releases byte enables at cycle plus beats, latch at latch release time
// R07: select and output enable release at release time
// R08: ratio zero: select on clock edge, optional half
// R09: ratio one: parity decides one clock lag
// R10: ratio two: lag is difference modulo three
// R11: ratio three: lag is difference modulo four
// R12: latch assertion uses same offset scheme
// R13: read latch release uses read release time
// R14: write latch release uses write release time
// R15: ratio zero: output enable on edge, optional half
// R16: memory clock divided by programmed ratio
// R17: write enable follows same placement scheme
// R18: half shifts launch from falling clock edge
// R19: beats counted to match burst length
module snep_top
  import snep_pkg::*;
(
  input  wire logic          mclk,                           // functional clock
  input  wire logic          nrst,                           // synchronous reset, active low
  input  wire logic          start,                          // one-cycle access request
  input  wire logic          is_write,                       // access is a write
  input  wire logic [NW-1:0] burst_beats,                    // beats n, 1 for single
  input  wire logic [1:0]    clock_divide_ratio,             // memory clock divide, 0 to 3
  input  wire logic [TW-1:0] first_clock_delay,              // fclk before first mem clock
  input  wire logic          timing_scale_bit,               // time unit is 1 or 2 fclk
  input  wire logic [TW-1:0] select_assert_time,             // select on time
  input  wire logic [TW-1:0] select_read_release_time,       // select off time, read
  input  wire logic [TW-1:0] select_write_release_time,      // select off time, write
  input  wire logic [TW-1:0] latch_assert_time,              // latch on time
  input  wire logic [TW-1:0] latch_read_release_time,        // latch off time, read
  input  wire logic [TW-1:0] latch_write_release_time,       // latch off time, write
  input  wire logic [TW-1:0] oe_assert_time,                 // output enable on time
  input  wire logic [TW-1:0] oe_release_time,                // output enable off time
  input  wire logic [TW-1:0] we_assert_time,                 // write enable on time
  input  wire logic [TW-1:0] we_release_time,                // write enable off time
  input  wire logic [TW-1:0] read_cycle_length,              // read cycle length
  input  wire logic [TW-1:0] write_cycle_length,             // write cycle length
  input  wire logic [TW-1:0] data_sample_time,               // first data beat time
  input  wire logic [3:0]    burst_beat_time,                // time between beats
  input  wire logic          select_half_cycle_shift,        // half shift on select
  input  wire logic          latch_half_cycle_shift,         // half shift on latch
  input  wire logic          output_enable_half_cycle_shift, // half shift on output enable
  input  wire logic          write_enable_half_cycle_shift,  // half shift on write enable
  output logic               busy,                           // access in progress
  output logic               mem_clk,                        // memory clock out
  output logic               cs_n,                           // chip select, active low
  output logic               be_n,                           // byte enables, active low
  output logic               latch_n,                        // address latch, active low
  output logic               oe_n,                           // output enable, active low
  output logic               we_n,                           // write enable, active low
  output logic               beat_pulse,                     // one pulse per data beat
  output logic [NW-1:0]      beat_count                      // beats done so far
);
  snep_state_t    st_q, st_d;
  logic [CW-1:0]  t_q, t_d;
  logic [UW-1:0]  u_q, u_d;
  logic           sub_q, sub_d;
  logic [PW-1:0]  ph_q, ph_d;
  logic           clk_on_q, clk_on_d;
  logic           mclk_q, mclk_d;
  logic           tog_q, tog_d;
  logic           tog_nq;
  logic [UW-1:0]  next_q, next_d;
  logic [NW-1:0]  cnt_q, cnt_d;
  logic           pulse_q, pulse_d;
  logic           cs_lvl_q, cs_lvl_d;
  logic           be_lvl_q, be_lvl_d;
  logic           adv_lvl_q, adv_lvl_d;
  logic           oe_lvl_d, we_lvl_d;
  logic [XW-1:0]  ext;
  logic [UW-1:0]  cs_off, be_off, adv_off, oe_off, we_off, end_u;
  logic [PW-1:0]  half;
  logic           run_d;

  // inputs are expected to hold still for the whole access
  always_comb begin
    ext     = XW'((burst_beats - BEAT_ONE) * burst_beat_time);                   // R19
    cs_off  = UW'(is_write ? select_write_release_time
                           : select_read_release_time) + UW'(ext);               // R02 R03
    be_off  = UW'(is_write ? write_cycle_length : read_cycle_length) + UW'(ext); // R05
    adv_off = UW'(is_write ? latch_write_release_time : latch_read_release_time); // R13 R14
    oe_off  = UW'(oe_release_time) + UW'(ext);
    we_off  = UW'(we_release_time) + UW'(ext);
    end_u   = (cs_off > be_off) ? cs_off : be_off;
    half    = PW'((3'(clock_divide_ratio) + 3'h2) >> 1);
  end

  // access sequencer and time base; one unit is one or two functional clocks
  always_comb begin
    st_d  = st_q;
    t_d   = t_q;
    u_d   = u_q;
    sub_d = sub_q;
    case (st_q)
      SNEP_IDLE: begin
        if (start) begin
          st_d  = SNEP_RUN;
          t_d   = '0;
          u_d   = '0;
          sub_d = 1'b0;
        end
      end
      SNEP_RUN: begin
        t_d   = t_q + CW'(1);
        sub_d = timing_scale_bit ? ~sub_q : 1'b0;
        u_d   = u_q + UW'(sub_q == timing_scale_bit);                           // R01
        if (u_d >= end_u) begin
          st_d = SNEP_IDLE;
        end
      end
      default: st_d = SNEP_IDLE;
    endcase
    run_d = (st_d == SNEP_RUN);
  end

  // strobe levels follow the unit count, so edges land on (time x scale) fclk
  always_comb begin
    cs_lvl_d  = run_d && u_d >= UW'(select_assert_time) && u_d < cs_off;       // R01 R07
    be_lvl_d  = run_d && u_d < be_off;                                         // R05 R06
    adv_lvl_d = run_d && u_d >= UW'(latch_assert_time) && u_d < adv_off;       // R12 R06
    oe_lvl_d  = run_d && !is_write && u_d >= UW'(oe_assert_time) && u_d < oe_off; // R07
    we_lvl_d  = run_d && is_write && u_d >= UW'(we_assert_time) && u_d < we_off;  // R17
  end

  // memory clock rises where (t - first_clock_delay) is a multiple of ratio+1,
  // so strobe lag against it falls out as the parity or modulo offset
  always_comb begin
    clk_on_d = run_d && t_d >= CW'(first_clock_delay);                         // R04
    if (t_d == CW'(first_clock_delay) || ph_q == clock_divide_ratio) begin
      ph_d = PHASE_RST;                                                        // R09 R10 R11
    end else begin
      ph_d = ph_q + PW'(1);
    end
    mclk_d = clk_on_d && ph_d < half;                                          // R16
    tog_d  = clk_on_d ? ~tog_q : tog_q;
  end

  // beat tracking
  always_comb begin
    next_d  = next_q;
    cnt_d   = cnt_q;
    pulse_d = 1'b0;
    if (st_q == SNEP_IDLE) begin
      if (start) begin
        next_d = UW'(data_sample_time);
        cnt_d  = '0;
      end
    end else if (run_d && u_d == next_q && !sub_d && cnt_q < burst_beats) begin
      pulse_d = 1'b1;                                                          // R19
      cnt_d   = cnt_q + NW'(1);
      next_d  = next_q + UW'(burst_beat_time);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_q      <= SNEP_IDLE;
      t_q       <= '0;
      u_q       <= '0;
      sub_q     <= 1'b0;
      ph_q      <= PHASE_RST;
      clk_on_q  <= 1'b0;
      mclk_q    <= 1'b0;
      tog_q     <= 1'b0;
      next_q    <= '0;
      cnt_q     <= '0;
      pulse_q   <= 1'b0;
      cs_lvl_q  <= 1'b0;
      be_lvl_q  <= 1'b0;
      adv_lvl_q <= 1'b0;
      busy      <= 1'b0;
    end else begin
      st_q      <= st_d;
      t_q       <= t_d;
      u_q       <= u_d;
      sub_q     <= sub_d;
      ph_q      <= ph_d;
      clk_on_q  <= clk_on_d;
      mclk_q    <= mclk_d;
      tog_q     <= tog_d;
      next_q    <= next_d;
      cnt_q     <= cnt_d;
      pulse_q   <= pulse_d;
      cs_lvl_q  <= cs_lvl_d;
      be_lvl_q  <= be_lvl_d;
      adv_lvl_q <= adv_lvl_d;
      busy      <= run_d;
    end
  end

  always_ff @(negedge mclk) begin
    if (!nrst) begin
      tog_nq <= 1'b0;
    end else begin
      tog_nq <= tog_q;
    end
  end

  // at ratio 0 the clock runs at fclk rate, high from rising to falling edge
  assign mem_clk    = (clock_divide_ratio == 2'h0) ? (tog_q ^ tog_nq) : mclk_q; // R16 R08
  assign beat_pulse = pulse_q;
  assign beat_count = cnt_q;
  assign be_n       = ~be_lvl_q;

  snep_launch u_cs (
    .mclk       (mclk),
    .nrst       (nrst),
    .level_d    (cs_lvl_d),
    .half_shift (select_half_cycle_shift),
    .strobe_n   (cs_n)
  ); // R08
  snep_launch u_adv (
    .mclk       (mclk),
    .nrst       (nrst),
    .level_d    (adv_lvl_d),
    .half_shift (latch_half_cycle_shift),
    .strobe_n   (latch_n)
  ); // R12
  snep_launch u_oe (
    .mclk       (mclk),
    .nrst       (nrst),
    .level_d    (oe_lvl_d),
    .half_shift (output_enable_half_cycle_shift),
    .strobe_n   (oe_n)
  ); // R15
  snep_launch u_we (
    .mclk       (mclk),
    .nrst       (nrst),
    .level_d    (we_lvl_d),
    .half_shift (write_enable_half_cycle_shift),
    .strobe_n   (we_n)
  ); // R17

  // helper counters of low time for the duration checks
  logic [CW-1:0] cs_len_q, be_len_q, adv_len_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cs_len_q  <= '0;
      be_len_q  <= '0;
      adv_len_q <= '0;
    end else begin
      cs_len_q  <= cs_lvl_q ? cs_len_q + CW'(1) : '0;
      be_len_q  <= be_lvl_q ? be_len_q + CW'(1) : '0;
      adv_len_q <= adv_lvl_q ? adv_len_q + CW'(1) : '0;
    end
  end

  AST_CS_LEN: assert property (@(posedge mclk) disable iff (!nrst) // R01 R02 R03
    $fell(cs_lvl_q) && !start |->
      32'(cs_len_q) == (32'(cs_off) - 32'(select_assert_time)) * (32'(timing_scale_bit) + 1))
    else $error("select low time wrong");
  AST_BE_LEN: assert property (@(posedge mclk) disable iff (!nrst) // R05 R06
    $fell(be_lvl_q) && !start |->
      32'(be_len_q) == 32'(be_off) * (32'(timing_scale_bit) + 1))
    else $error("byte enable low time wrong");
  AST_ADV_LEN: assert property (@(posedge mclk) disable iff (!nrst) // R13 R14
    $fell(adv_lvl_q) && !start |->
      32'(adv_len_q) == (32'(adv_off) - 32'(latch_assert_time)) * (32'(timing_scale_bit) + 1))
    else $error("latch low time wrong");
  AST_FIRST_CLK: assert property (@(posedge mclk) disable iff (!nrst) // R04
    $rose(clk_on_q) |-> t_q == CW'(first_clock_delay))
    else $error("memory clock started at wrong time");
  AST_PHASE: assert property (@(posedge mclk) disable iff (!nrst) // R16
    clk_on_q |-> ph_q <= clock_divide_ratio)
    else $error("clock phase beyond divide ratio");
  AST_CS_LAG: assert property (@(posedge mclk) disable iff (!nrst) // R09 R10 R11
    $rose(cs_lvl_q) && clk_on_q && !timing_scale_bit |->
      32'(ph_q) == (32'(t_q) - 32'(first_clock_delay)) % (32'(clock_divide_ratio) + 1))
    else $error("select lag against memory clock wrong");
  AST_BEATS: assert property (@(posedge mclk) disable iff (!nrst) // R19
    $fell(busy) && burst_beats > 0 && next_q <= end_u |-> ##[0:1] cnt_q <= burst_beats)
    else $error("beat count exceeds burst length");
  AST_WE_READ: assert property (@(posedge mclk) disable iff (!nrst) // R17 R07
    busy && !is_write |-> we_n)
    else $error("write enable asserted on a read");
endmodule

// ---- snep_flash_model.sv ----
`timescale 1ns/100ps
module snep_flash_model
  import snep_pkg::*;
(
  input  wire logic       mclk,     // functional clock, used to sample the strobes
  input  wire logic       nrst,     // synchronous reset, active low
  input  wire logic       cs_n,     // chip select from the controller
  input  wire logic       latch_n,  // address latch from the controller
  input  wire logic       oe_n,     // output enable from the controller
  input  wire logic       we_n,     // write enable from the controller
  output logic            clash_q,  // output and write enable seen low together while selected
  output logic [7:0]      latches_q // address latch pulses seen
);
  logic latch_prev_q;

  // the part would fight the controller on its bus if both enables met while selected
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clash_q      <= 1'b0;
      latches_q    <= 8'h00;
      latch_prev_q <= 1'b1;
    end else begin
      latch_prev_q <= latch_n;
      if (!cs_n && !oe_n && !we_n)
        clash_q <= 1'b1;
      if (latch_prev_q && !latch_n)
        latches_q <= latches_q + 8'h01;
    end
  end
endmodule

// ---- sync_nor_edge_placement_test.sv ----
`timescale 1ns/100ps
module sync_nor_edge_placement_test;
  import snep_pkg::*;
  logic mclk, nrst, start, is_write, timing_scale_bit, busy, mem_clk, cs_n, be_n;
  logic latch_n, oe_n, we_n, beat_pulse, clash_q;
  logic select_half_cycle_shift, latch_half_cycle_shift;
  logic output_enable_half_cycle_shift, write_enable_half_cycle_shift;
  logic [NW-1:0] burst_beats, beat_count;
  logic [1:0]    clock_divide_ratio;
  logic [3:0]    burst_beat_time;
  logic [7:0]    latches_q;
  logic [TW-1:0] first_clock_delay, select_assert_time, select_read_release_time;
  logic [TW-1:0] select_write_release_time, latch_assert_time, latch_read_release_time;
  logic [TW-1:0] latch_write_release_time, oe_assert_time, oe_release_time;
  logic [TW-1:0] we_assert_time, we_release_time, read_cycle_length;
  logic [TW-1:0] write_cycle_length, data_sample_time;
  int            num_errors, comparisons, cyc;
  int            csf, csl, bel, lf, lr, oel, oef, wel, c1, c2, bp, bz;

  snep_top DUT (.mclk, .nrst, .start, .is_write, .burst_beats, .clock_divide_ratio,
    .first_clock_delay, .timing_scale_bit, .select_assert_time, .select_read_release_time,
    .select_write_release_time, .latch_assert_time, .latch_read_release_time,
    .latch_write_release_time, .oe_assert_time, .oe_release_time, .we_assert_time,
    .we_release_time, .read_cycle_length, .write_cycle_length, .data_sample_time,
    .burst_beat_time, .select_half_cycle_shift, .latch_half_cycle_shift,
    .output_enable_half_cycle_shift, .write_enable_half_cycle_shift, .busy, .mem_clk,
    .cs_n, .be_n, .latch_n, .oe_n, .we_n, .beat_pulse, .beat_count);

  snep_flash_model flash (.mclk, .nrst, .cs_n, .latch_n, .oe_n, .we_n, .clash_q, .latches_q);

  always #5 mclk = ~mclk;

  task automatic close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a hung access must still reach the report
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic set_mode(input logic [1:0] r, input logic s, input logic [4:0] fcd,
                          input logic [4:0] on, input logic [3:0] sh);
    clock_divide_ratio <= r;
    timing_scale_bit <= s;
    first_clock_delay <= fcd;
    select_assert_time <= on;
    {select_half_cycle_shift, latch_half_cycle_shift} <= sh[3:2];
    {output_enable_half_cycle_shift, write_enable_half_cycle_shift} <= sh[1:0];
  endtask

  // one access, sampled just after each rising edge; mid-cycle look at the memory clock
  task automatic acc(input logic wr, input logic [NW-1:0] n, input logic again);
    int  i;
    int  post;
    logic mid;
    is_write <= wr;
    burst_beats <= n;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    csf = -1;
    lf = -1;
    oef = -1;
    c1 = -1;
    c2 = -1;
    csl = 0;
    bel = 0;
    lr = 0;
    oel = 0;
    wel = 0;
    bp = 0;
    bz = 0;
    mid = 1'b0;
    post = 0;
    for (i = 0; i < 400 && post < 4; i++) begin
      #1;
      if (busy !== 1'b1) post++;
      else bz++;
      if (cs_n === 1'b0 && csf < 0) csf = i;
      if (cs_n === 1'b0) csl++;
      if (be_n === 1'b0) bel++;
      if (latch_n === 1'b0 && lf < 0) lf = i;
      if (latch_n === 1'b0) lr = i + 1;
      if (oe_n === 1'b0) oel++;
      if (oe_n === 1'b0 && oef < 0) oef = i;
      if (we_n === 1'b0) wel++;
      if (beat_pulse === 1'b1) bp++;
      if (mem_clk === 1'b1 && mid === 1'b0) begin
        if (c1 < 0) c1 = i;
        else if (c2 < 0) c2 = i;
      end
      @(negedge mclk);
      #1 mid = mem_clk;
      @(posedge mclk);
      // touch start only here, so the next access may raise it at the same edge
      if (again && (i == 1 || i == 2)) begin
        start <= (i == 1);
      end
    end
  endtask

  task automatic expect_all(input logic wr, input int n);
    int u, bt, p, on, fcd, rel, cyc_len, csh;
    u = timing_scale_bit + 1;
    bt = (n - 1) * burst_beat_time;
    p = clock_divide_ratio + 1;
    on = select_assert_time;
    fcd = first_clock_delay;
    csh = select_half_cycle_shift;
    rel = wr ? select_write_release_time : select_read_release_time;
    cyc_len = wr ? write_cycle_length : read_cycle_length;
    cmp(16'(csf), 16'(on * u + csh));
    cmp(16'(csl), 16'((rel - on + bt) * u));
    cmp(16'(bel), 16'((cyc_len + bt) * u));
    cmp(16'(lf), 16'(latch_assert_time * u + latch_half_cycle_shift));
    cmp(16'(lr), 16'((wr ? latch_write_release_time : latch_read_release_time) * u
                     + latch_half_cycle_shift));
    cmp(16'(oel), 16'(wr ? 0 : (oe_release_time - oe_assert_time + bt) * u));
    cmp(16'(oef), 16'(wr ? -1 : oe_assert_time * u + output_enable_half_cycle_shift));
    cmp(16'(wel), 16'(wr ? (we_release_time - we_assert_time + bt) * u : 0));
    cmp(16'(c1), 16'(fcd));
    cmp(16'(c2 - c1), 16'(p));
    if (u == 1)
      cmp(16'((csf - csh - c1 + 64 * p) % p), 16'((on - fcd + 64 * p) % p));
    cmp(16'(bp), 16'(n));
    cmp(16'(bz), 16'((rel > cyc_len ? rel + bt : cyc_len + bt) * u));
    cmp({11'h000, beat_count}, 16'(n));
  endtask

  task automatic t_single_read;
    set_mode(2'h0, 1'b1, 5'h01, 5'h01, 4'ha);
    acc(1'b0, 5'h01, 1'b0);
    expect_all(1'b0, 1);
  endtask

  // second start in mid access must leave the timing untouched
  task automatic t_burst_read;
    set_mode(2'h1, 1'b0, 5'h02, 5'h01, 4'h0);
    acc(1'b0, 5'h04, 1'b1);
    expect_all(1'b0, 4);
  endtask

  task automatic t_burst_write;
    set_mode(2'h2, 1'b0, 5'h03, 5'h01, 4'h1);
    acc(1'b1, 5'h03, 1'b0);
    expect_all(1'b1, 3);
  endtask

  task automatic t_ratio_three;
    set_mode(2'h3, 1'b0, 5'h01, 5'h03, 4'h4);
    acc(1'b0, 5'h02, 1'b0);
    expect_all(1'b0, 2);
  endtask

  initial begin
    {mclk, nrst, start, is_write, timing_scale_bit} = '0;
    {select_half_cycle_shift, latch_half_cycle_shift} = '0;
    {output_enable_half_cycle_shift, write_enable_half_cycle_shift} = '0;
    {num_errors, comparisons, cyc} = '0;
    burst_beats = 5'h01;
    clock_divide_ratio = 2'h0;
    burst_beat_time = 4'h2;
    first_clock_delay = 5'h01;
    select_assert_time = 5'h01;
    select_read_release_time = 5'h04;
    select_write_release_time = 5'h04;
    latch_assert_time = 5'h00;
    latch_read_release_time = 5'h02;
    latch_write_release_time = 5'h03;
    oe_assert_time = 5'h02;
    oe_release_time = 5'h04;
    we_assert_time = 5'h01;
    we_release_time = 5'h04;
    read_cycle_length = 5'h05;
    write_cycle_length = 5'h06;
    data_sample_time = 5'h03;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_single_read();
    t_burst_read();
    t_burst_write();
    t_ratio_three();
    cmp({15'h0000, clash_q}, 16'h0000);
    cmp({8'h00, latches_q}, 16'h0004);
    close_out();
  end
endmodule
